/* File: src/freq_detector.v */
// Purpose: Register block and window measurement of a frequency detector
// Assumes: Reference and target clocks arrive as pins, sampled on aclk
// Notes:   One write and one read in flight; either order of aw and w
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.

`include "ofd_consts.vh"

// Function
// - Internal upper limit, nine bits low
// - External upper limit, nine bits low
// - Internal upper limit frozen while running
// - External upper limit frozen while running
// - Reset request enable, resets to one
// - Reset control frozen while running
// - Status bit1 zero running, one stopped; the code holds it at one for the first two windows after enable
// - Status bit0 error flag, resets zero
// - Monitor zero checks selected oscillator
// - Monitor one checks external, resets one
// - Writes other than key and interrupt status need unlock key; others relock
// - Runs only with enable code written
// - Out-of-limit result with enable requests reset
// - One measurement per 256 reference periods
module freq_detector (
  // Clock, reset, enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  // AXI4-Lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Clock pins and oscillator selection
  input  wire        ref_clk_pin,
  input  wire        internal_oscillator_one,
  input  wire        external_oscillator,
  input  wire        osc_select_external,
  // Results
  output wire        reset_request,
  output wire        irq
);

  // Merge write data into a register by byte strobe
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // Offset is one of the mapped registers
  function mapped;
    input [`OFD_ADDR_W-1:0] a;
    begin
      case (a)
        `OFD_KEY_OFS, `OFD_DET_EN_OFS, `OFD_LOW0_OFS, `OFD_LOW1_OFS,
        `OFD_UP0_OFS, `OFD_UP1_OFS, `OFD_RSTCTL_OFS, `OFD_STAT_OFS,
        `OFD_MON_OFS, `OFD_IRQ_STAT_OFS, `OFD_IRQ_MASK_OFS: begin
          mapped = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // Bus state
  reg                   awready_ff;
  reg                   wready_ff;
  reg                   bvalid_ff;
  reg [1:0]             bresp_ff;
  reg                   arready_ff;
  reg                   rvalid_ff;
  reg [31:0]            rdata_ff;
  reg [1:0]             rresp_ff;
  reg                   aw_held_ff;
  reg                   w_held_ff;
  reg [`OFD_ADDR_W-1:0] waddr_ff;
  reg [31:0]            wdata_ff;
  reg [3:0]             wstrb_ff;
  reg                   wbad_ff;

  // Registers
  reg [7:0]             key_ff;
  reg [7:0]             det_en_ff;
  reg [`OFD_LIM_W-1:0]  low0_ff;
  reg [`OFD_LIM_W-1:0]  low1_ff;
  reg [`OFD_LIM_W-1:0]  internal_upper_limit_ff;
  reg [`OFD_LIM_W-1:0]  external_upper_limit_ff;
  reg                   reset_request_enable_ff;
  reg                   monitor_target_select_ff;
  reg                   frequency_error_flag_ff;
  reg                   detector_stopped_flag_ff;
  reg [`OFD_EV_W-1:0]   irq_stat_ff;
  reg [`OFD_EV_W-1:0]   irq_mask_ff;
  reg                   irq_ff;
  reg                   reset_request_ff;

  // Pin synchronisers and edge history
  reg [2:0]             ref_sync_ff;
  reg [2:0]             int_sync_ff;
  reg [2:0]             ext_sync_ff;

  // Measurement
  reg [`OFD_WIN_W-1:0]  win_cnt_ff;
  reg [`OFD_CNT_W-1:0]  tgt_cnt_ff;
  reg [`OFD_WARM_W-1:0] warm_ff;

  wire running = (det_en_ff == `OFD_DET_ON);
  wire unlocked = (key_ff == `OFD_KEY_UNLOCK);
  wire cfg_ok = unlocked && !running;

  // Write commit when address and data are both held
  wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [31:0] wval = merge(32'h00000000, wdata_ff, wstrb_ff);
  // Byte-merged limit values, cut to the field below
  wire [31:0] low0_m = merge({23'h000000, low0_ff}, wdata_ff, wstrb_ff);
  wire [31:0] low1_m = merge({23'h000000, low1_ff}, wdata_ff, wstrb_ff);
  wire [31:0] up0_m  = merge({23'h000000, internal_upper_limit_ff},
                             wdata_ff, wstrb_ff);
  wire [31:0] up1_m  = merge({23'h000000, external_upper_limit_ff},
                             wdata_ff, wstrb_ff);
  wire do_read = s_axi_arvalid && arready_ff;
  wire [`OFD_ADDR_W-1:0] raddr = s_axi_araddr[`OFD_ADDR_W-1:0];
  wire rbad = (s_axi_araddr[31:`OFD_ADDR_W] != 26'h0000000) ||
              !mapped(raddr);

  // Target selection
  wire use_ext = monitor_target_select_ff || osc_select_external;
  wire ref_edge = ref_sync_ff[1] && !ref_sync_ff[2];
  wire tgt_edge = use_ext ? (ext_sync_ff[1] && !ext_sync_ff[2])
                          : (int_sync_ff[1] && !int_sync_ff[2]);
  wire win_end = running && ref_edge && (win_cnt_ff == `OFD_WIN_LAST);
  wire [`OFD_LIM_W-1:0] up_lim = use_ext ? external_upper_limit_ff
                                         : internal_upper_limit_ff;
  wire [`OFD_LIM_W-1:0] low_lim = use_ext ? low1_ff : low0_ff;
  wire [`OFD_CNT_W-1:0] scaled = tgt_cnt_ff >> `OFD_CNT_SHIFT;
  wire out_of_range = (scaled > {3'h0, up_lim}) ||
                      (scaled < {3'h0, low_lim});
  wire judge = win_end && (warm_ff == `OFD_WARM_DONE);
  wire [`OFD_EV_W-1:0] events;
  assign events[`OFD_EV_ERR_BIT] = judge && out_of_range;
  assign events[`OFD_EV_WIN_BIT] = judge;

  // Read data mux
  reg [31:0] rmux;
  always @* begin
    rmux = 32'h00000000;
    case (raddr)
      `OFD_KEY_OFS:      rmux[7:0] = key_ff;
      `OFD_DET_EN_OFS:   rmux[7:0] = det_en_ff;
      `OFD_LOW0_OFS:     rmux[`OFD_LIM_W-1:0] = low0_ff;
      `OFD_LOW1_OFS:     rmux[`OFD_LIM_W-1:0] = low1_ff;
      `OFD_UP0_OFS:      rmux[`OFD_LIM_W-1:0] = internal_upper_limit_ff;
      `OFD_UP1_OFS:      rmux[`OFD_LIM_W-1:0] = external_upper_limit_ff;
      `OFD_RSTCTL_OFS:   rmux[0] = reset_request_enable_ff;
      `OFD_STAT_OFS: begin
        rmux[`OFD_STAT_ERR_BIT] = frequency_error_flag_ff;
        rmux[`OFD_STAT_STOP_BIT] = detector_stopped_flag_ff;
      end
      `OFD_MON_OFS:      rmux[0] = monitor_target_select_ff;
      `OFD_IRQ_STAT_OFS: rmux[`OFD_EV_W-1:0] = irq_stat_ff;
      `OFD_IRQ_MASK_OFS: rmux[`OFD_EV_W-1:0] = irq_mask_ff;
      default:           rmux = 32'h00000000;
    endcase
  end

  // Bus channels
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `AXI_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `AXI_RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      waddr_ff   <= {`OFD_ADDR_W{1'b0}};
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      wbad_ff    <= 1'b0;
    end else if (clk_en) begin
      awready_ff <= !aw_held_ff && !(s_axi_awvalid && awready_ff) &&
                    !bvalid_ff;
      wready_ff  <= !w_held_ff && !(s_axi_wvalid && wready_ff) &&
                    !bvalid_ff;
      if (s_axi_awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        waddr_ff   <= s_axi_awaddr[`OFD_ADDR_W-1:0];
        wbad_ff    <= (s_axi_awaddr[31:`OFD_ADDR_W] != 26'h0000000) ||
                      !mapped(s_axi_awaddr[`OFD_ADDR_W-1:0]);
      end
      if (s_axi_wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wbad_ff ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      arready_ff <= !rvalid_ff && !do_read;
      if (do_read) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rbad ? 32'h00000000 : rmux;
        rresp_ff  <= rbad ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      key_ff                   <= `OFD_KEY_LOCK;
      det_en_ff                <= `OFD_DET_OFF;
      low0_ff                  <= `OFD_LIM_RST;
      low1_ff                  <= `OFD_LIM_RST;
      internal_upper_limit_ff  <= `OFD_LIM_RST;
      external_upper_limit_ff  <= `OFD_LIM_RST;
      reset_request_enable_ff  <= `OFD_RSTEN_RST;
      monitor_target_select_ff <= `OFD_MON_RST;
      irq_mask_ff              <= {`OFD_EV_W{1'b0}};
    end else if (clk_en && do_write && !wbad_ff) begin
      case (waddr_ff)
        `OFD_KEY_OFS: begin
          if (wstrb_ff[0]) begin
            key_ff <= (wval[7:0] == `OFD_KEY_UNLOCK) ?
                      `OFD_KEY_UNLOCK : `OFD_KEY_LOCK;
          end
        end
        `OFD_DET_EN_OFS: begin
          if (unlocked && wstrb_ff[0] &&
              (wval[7:0] == `OFD_DET_ON ||
               wval[7:0] == `OFD_DET_OFF)) begin
            det_en_ff <= wval[7:0];
          end
        end
        `OFD_LOW0_OFS: begin
          if (cfg_ok) begin
            low0_ff <= low0_m[`OFD_LIM_W-1:0];
          end
        end
        `OFD_LOW1_OFS: begin
          if (cfg_ok) begin
            low1_ff <= low1_m[`OFD_LIM_W-1:0];
          end
        end
        `OFD_UP0_OFS: begin
          if (cfg_ok) begin
            internal_upper_limit_ff <= up0_m[`OFD_LIM_W-1:0];
          end
        end
        `OFD_UP1_OFS: begin
          if (cfg_ok) begin
            external_upper_limit_ff <= up1_m[`OFD_LIM_W-1:0];
          end
        end
        `OFD_RSTCTL_OFS: begin
          if (cfg_ok && wstrb_ff[0]) begin
            reset_request_enable_ff <= wval[0];
          end
        end
        `OFD_MON_OFS: begin
          if (cfg_ok && wstrb_ff[0]) begin
            monitor_target_select_ff <= wval[0];
          end
        end
        `OFD_IRQ_MASK_OFS: begin
          if (unlocked && wstrb_ff[0]) begin
            irq_mask_ff <= wval[`OFD_EV_W-1:0];
          end
        end
        default: begin
          key_ff <= key_ff;
        end
      endcase
    end
  end

  // Pin synchronisers and window measurement
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_sync_ff <= 3'h0;
      int_sync_ff <= 3'h0;
      ext_sync_ff <= 3'h0;
      win_cnt_ff  <= {`OFD_WIN_W{1'b0}};
      tgt_cnt_ff  <= {`OFD_CNT_W{1'b0}};
      warm_ff     <= {`OFD_WARM_W{1'b0}};
    end else if (clk_en) begin
      ref_sync_ff <= {ref_sync_ff[1:0], ref_clk_pin};
      int_sync_ff <= {int_sync_ff[1:0], internal_oscillator_one};
      ext_sync_ff <= {ext_sync_ff[1:0], external_oscillator};
      if (!running) begin
        win_cnt_ff <= {`OFD_WIN_W{1'b0}};
        tgt_cnt_ff <= {`OFD_CNT_W{1'b0}};
        warm_ff    <= {`OFD_WARM_W{1'b0}};
      end else if (win_end) begin
        win_cnt_ff <= {`OFD_WIN_W{1'b0}};
        tgt_cnt_ff <= {`OFD_CNT_W{1'b0}};
        if (warm_ff != `OFD_WARM_DONE) begin
          warm_ff <= warm_ff + 2'h1;
        end
      end else begin
        if (ref_edge) begin
          win_cnt_ff <= win_cnt_ff + 8'h01;
        end
        if (tgt_edge && tgt_cnt_ff != `OFD_CNT_MAX) begin
          tgt_cnt_ff <= tgt_cnt_ff + 12'h001;
        end
      end
    end
  end

  // Status, interrupt and reset request
  always @(posedge aclk) begin
    if (!aresetn) begin
      frequency_error_flag_ff  <= 1'b0;
      detector_stopped_flag_ff <= 1'b1;
      irq_stat_ff              <= {`OFD_EV_W{1'b0}};
      irq_ff                   <= 1'b0;
      reset_request_ff         <= 1'b0;
    end else if (clk_en) begin
      detector_stopped_flag_ff <= !(running &&
                                    warm_ff == `OFD_WARM_DONE);
      if (!running) begin
        frequency_error_flag_ff <= 1'b0;
      end else if (judge) begin
        frequency_error_flag_ff <= out_of_range;
      end
      if (do_write && !wbad_ff && waddr_ff == `OFD_IRQ_STAT_OFS &&
          wstrb_ff[0]) begin
        irq_stat_ff <= (irq_stat_ff & ~wval[`OFD_EV_W-1:0]) | events;
      end else begin
        irq_stat_ff <= irq_stat_ff | events;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
      reset_request_ff <= running && reset_request_enable_ff &&
                          frequency_error_flag_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign reset_request = reset_request_ff;
  assign irq           = irq_ff;

endmodule // freq_detector

/* File: src/ofd_consts.vh */
// Purpose: Constants of the oscillation frequency detector register block
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes:   Offsets are byte addresses within the block
`ifndef OFD_CONSTS_VH
`define OFD_CONSTS_VH

// Register offsets
`define OFD_ADDR_W          6
`define OFD_KEY_OFS         6'h00
`define OFD_DET_EN_OFS      6'h04
`define OFD_LOW0_OFS        6'h08
`define OFD_LOW1_OFS        6'h0C
`define OFD_UP0_OFS         6'h10
`define OFD_UP1_OFS         6'h14
`define OFD_RSTCTL_OFS      6'h18
`define OFD_STAT_OFS        6'h1C
`define OFD_MON_OFS         6'h20
`define OFD_IRQ_STAT_OFS    6'h24
`define OFD_IRQ_MASK_OFS    6'h28

// Codes and reset values
`define OFD_KEY_UNLOCK      8'hF9
`define OFD_KEY_LOCK        8'h06
`define OFD_DET_ON          8'hE4
`define OFD_DET_OFF         8'h00
`define OFD_LIM_W           9
`define OFD_LIM_RST         9'h000
`define OFD_RSTEN_RST       1'h1
`define OFD_MON_RST         1'h1

// Status and interrupt bit positions
`define OFD_STAT_ERR_BIT    0
`define OFD_STAT_STOP_BIT   1
`define OFD_EV_W            2
`define OFD_EV_ERR_BIT      0
`define OFD_EV_WIN_BIT      1

// Measurement
`define OFD_WIN_W           8
`define OFD_WIN_LAST        8'hFF
`define OFD_CNT_W           12
`define OFD_CNT_MAX         12'hFFF
`define OFD_CNT_SHIFT       2
`define OFD_WARM_W          2
`define OFD_WARM_DONE       2'h2

// Bus responses
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

/* File: testbench/freq_detector_props.sv */
// Purpose: Bus timing and read-back field checks of freq_detector
// Assumes: clk_en held high, one clock domain
// Notes:   Bound to every freq_detector instance
`include "ofd_consts.vh"
module freq_detector_props (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Write channels
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Read channels
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Results
  input wire        reset_request,
  input wire        irq
);
  reg [5:0] rd_a_ff;
  // Offset of the read in flight
  always @(posedge aclk) begin
    if (!aresetn)
      rd_a_ff <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_a_ff <= s_axi_araddr[5:0];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_bad_ar;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[31:6] != 26'h0);
  endsequence
  property p_wr_ans;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_bad_rd;
    s_bad_ar |=> s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  property p_rst_out;
    $rose(aresetn) |-> !irq && !reset_request && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_rsv_lim;
    s_axi_rvalid && (rd_a_ff == `OFD_UP0_OFS || rd_a_ff == `OFD_UP1_OFS)
      |-> s_axi_rdata[31:9] == 23'h0;
  endproperty
  property p_rsv_stat;
    s_axi_rvalid && rd_a_ff == `OFD_STAT_OFS |-> s_axi_rdata[31:2] == 30'h0;
  endproperty
  property p_rsv_bit;
    s_axi_rvalid && (rd_a_ff == `OFD_RSTCTL_OFS || rd_a_ff == `OFD_MON_OFS)
      |-> s_axi_rdata[31:1] == 31'h0;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write response late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read data late");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken during read data");
  a_bad_rd: assert property (p_bad_rd)
    else $error("unmapped read not refused");
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not idle after reset");
  a_rsv_lim: assert property (p_rsv_lim)
    else $error("limit upper bits not zero");
  a_rsv_stat: assert property (p_rsv_stat)
    else $error("status upper bits not zero");
  a_rsv_bit: assert property (p_rsv_bit)
    else $error("control upper bits not zero");
endmodule // freq_detector_props

bind freq_detector freq_detector_props u_freq_detector_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .reset_request(reset_request), .irq(irq)
);

/* File: testbench/freq_detector_bench.sv */
// Purpose: Self-checking bench of freq_detector
// Assumes: Pin clocks at aclk/4 or slower, 256-period window
// Notes:   Integer register model compared at every chkm read
module freq_detector_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 1024;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        ref_clk = 0, int_osc = 0, ext_osc = 0, sel_ext = 0;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, rst_req, irq;
  int          mismatches = 0, total_checks = 0;
  int          lk = 1, run = 0, int_half = 2, ext_half = 4, cyc = 0, a;
  int          m [0:10];
  int          wm [0:10] = '{0, 0, 'h1FF, 'h1FF, 'h1FF, 'h1FF, 1, 0, 1, 0, 3};
  logic [31:0] d;
  logic [1:0]  r;

  freq_detector u_freq_detector (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_clk_pin(ref_clk),
    .internal_oscillator_one(int_osc), .external_oscillator(ext_osc),
    .osc_select_external(sel_ext), .reset_request(rst_req), .irq(irq)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end
  // Pin clocks: reference period 4 cycles, targets 2*half cycles
  always @(posedge aclk) begin
    cyc     <= cyc + 1;
    ref_clk <= (cyc >> 1) & 1;
    int_osc <= (cyc / int_half) % 2;
    ext_osc <= (cyc / ext_half) % 2;
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    mismatches++;
    $display("BAD %0t got %h exp %h", $time, g, e);
  endtask
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) bad(g, e);
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    total_checks++;
    if (g !== e) bad(g, e);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) bad(g, e);
  endtask
  task automatic wr(input int ad, input int dt, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= ad;
    wdata   <= dt;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      r = bresp;
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) bad(0, 1);
    if (n == 50) close_out();
    chk_resp(r, er);
  endtask
  task automatic rd(input int ad);
    int n;
    @(posedge aclk);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) bad(0, 1);
    if (n == 50) close_out();
  endtask
  task automatic chkm(input int ad);
    rd(ad);
    chk_data(d, m[ad >> 2]);
    chk_resp(r, 2'h0);
  endtask
  // Model update, then the bus write itself
  task automatic mw(input int ad, input int dt);
    int i;
    i = ad >> 2;
    if (ad == 0)
      lk = (dt & 'hFF) != 'hF9;
    else if (ad == 4 && !lk && ((dt & 'hFF) == 0 || (dt & 'hFF) == 'hE4)) begin
      run  = (dt & 'hFF) == 'hE4;
      m[1] = dt & 'hFF;
    end else if (ad == 'h24)
      m[9] = m[9] & ~dt;
    else if (!lk && (!run || i == 10) && wm[i] != 0)
      m[i] = dt & wm[i];
    wr(ad, dt, 2'h0);
  endtask
  task automatic do_reset;
    m       = '{0, 0, 0, 0, 0, 0, 1, 2, 1, 0, 0};
    lk      = 1;
    run     = 0;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (a = 4; a <= 'h28; a += 4) chkm(a);
  endtask

  initial begin
    void'($urandom(53325));
    do_reset();
    mw('h10, 'h1FF);
    chkm('h10);
    mw(0, 'hF9);
    for (a = 8; a <= 'h20; a += 4) mw(a, $urandom);
    for (a = 8; a <= 'h20; a += 4) chkm(a);
    mw(0, $urandom % 'hF9);
    mw('h14, 'h0AA);
    chkm('h14);
    wr('h2C, 0, 2'h2);
    rd('h40);
    chk_data(d, 0);
    chk_resp(r, 2'h2);
    mw(0, 'hF9);
    for (a = 8; a <= 'h14; a += 4) mw(a, a < 'h10 ? 'h30 : 'h50);
    mw('h18, 1);
    mw('h20, 0);
    mw('h28, 3);
    mw(4, 'hE4);
    for (a = 'h10; a <= 'h20; a += 4) if (a != 'h1C) mw(a, $urandom);
    for (a = 'h10; a <= 'h20; a += 4) if (a != 'h1C) chkm(a);
    repeat (3 * WIN) @(posedge aclk);
    m[7] = 0;
    chkm('h1C);
    chk_bit(rst_req, 1'b0);
    sel_ext <= 1'b1;
    repeat (2 * WIN) @(posedge aclk);
    m[7] = 1;
    chkm('h1C);
    chk_bit(rst_req, 1'b1);
    chk_bit(irq, 1'b1);
    mw(4, 0);
    m[7] = 2;
    m[9] = 3;
    for (a = 'h1C; a <= 'h24; a += 8) chkm(a);
    chk_bit(rst_req, 1'b0);
    mw('h24, 1);
    chkm('h24);
    mw('h28, 1);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    mw('h24, 2);
    chkm('h24);
    mw('h18, 0);
    mw('h20, 1);
    sel_ext <= 1'b0;
    mw(4, 'hE4);
    repeat (3 * WIN) @(posedge aclk);
    m[7] = 1;
    chkm('h1C);
    chk_bit(rst_req, 1'b0);
    do_reset();
    close_out();
  end
endmodule // freq_detector_bench
